/* core/eie_core.sv */
// Behaviour
// RQ1 - Subtract-to-memory writes accumulator minus the data byte into that byte and updates all six arithmetic flags.
// RQ2 - On subtraction the carry is 0 for a negative result and 1 for a positive or zero result.
// RQ3 - The in-place nibble swap exchanges the two nibbles of the data byte and changes no flag.
// RQ4 - The swap-to-accumulator form puts the swapped byte in the accumulator, leaving memory and flags alone.
// RQ5 - Byte skip-if-zero writes the byte back unchanged and skips the next instruction when it is zero.
// RQ6 - A skip adds two dummy cycles so the skipping instruction lasts three instruction cycles.
// RQ7 - Skip-if-zero-with-move copies the byte to the accumulator and skips when it is zero, flags unchanged.
// RQ8 - Bit skip-if-clear skips when the selected bit is 0 and changes no flag.
// RQ9 - Page table read fetches the word at pointer high and low, low byte to memory, high byte to the latch.
// RQ10 - Last-page table read addresses the last page by the low pointer only, with the same delivery.
// RQ11 - Pre-increment page table read increments the low pointer first, then does the page fetch.
// RQ12 - Pre-increment last-page table read increments the low pointer first, then fetches from the last page.
// RQ13 - XOR-to-accumulator stores accumulator XOR byte into the accumulator, updating only Z.
// RQ14 - XOR-to-memory stores accumulator XOR byte into the byte, updating only Z.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module eie_core #(
    parameter int PAW = 10,
    parameter int DMEM_WORDS = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic busy,
    output logic skip
);

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] dmem [DMEM_WORDS];
    logic [15:0] pmem [2**PAW];
    logic [7:0] acc_q, tptr_lo_q, tptr_hi_q, tlatch_q;
    eie_pkg::eie_flags_t flg_q;
    eie_pkg::eie_cmd_t cmd_q;
    eie_pkg::eie_state_t st_q;
    logic [1:0] dcnt_q;
    logic skip_q;
    logic busy_q;
    logic [PAW-1:0] pm_addr_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;

    function automatic logic [7:0] swap_nib(input logic [7:0] v);
        swap_nib = {v[3:0], v[7:4]};
    endfunction : swap_nib

    // ************************************************************
    // APB decode
    // ************************************************************
    wire access = psel & penable;
    wire commit = access & pready_q;
    wire wr_ok = commit & pwrite & (st_q == eie_pkg::S_IDLE);
    wire hit_dmem = (paddr >= eie_pkg::DMEM_OFS) && (paddr < 8'(eie_pkg::DMEM_OFS + 4 * DMEM_WORDS));
    wire [3:0] dm_idx = 4'((paddr - eie_pkg::DMEM_OFS) >> 2);
    wire mapped = hit_dmem || (paddr[1:0] == 2'b00 && paddr <= eie_pkg::PM_DATA_OFS);
    wire wr_cmd = wr_ok && paddr == eie_pkg::CMD_OFS;
    wire wr_acc = wr_ok && paddr == eie_pkg::ACC_OFS;
    wire wr_flg = wr_ok && paddr == eie_pkg::FLAGS_OFS;
    wire wr_tptr_lo = wr_ok && paddr == eie_pkg::TPTR_LO_OFS;
    wire wr_tptr_hi = wr_ok && paddr == eie_pkg::TPTR_HI_OFS;
    wire eie_pkg::eie_cmd_t cmd_in = {pwdata[eie_pkg::CMD_BIT_LSB +: 3], pwdata[eie_pkg::CMD_ADDR_LSB +: 4],
        pwdata[eie_pkg::CMD_OP_LSB +: 4]};
    wire [31:0] cmd_word = (32'(cmd_q.op) << eie_pkg::CMD_OP_LSB) | (32'(cmd_q.addr) << eie_pkg::CMD_ADDR_LSB)
        | (32'(cmd_q.bitsel) << eie_pkg::CMD_BIT_LSB);
    wire wr_pma = wr_ok && paddr == eie_pkg::PM_ADDR_OFS;
    wire wr_pmd = wr_ok && paddr == eie_pkg::PM_DATA_OFS;
    wire wr_dm = wr_ok && hit_dmem;

    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            eie_pkg::CMD_OFS: rd_word = cmd_word;
            eie_pkg::ACC_OFS: rd_word = {24'h0, acc_q};
            eie_pkg::FLAGS_OFS: rd_word = {26'h0, flg_q};
            eie_pkg::TPTR_LO_OFS: rd_word = {24'h0, tptr_lo_q};
            eie_pkg::TPTR_HI_OFS: rd_word = {24'h0, tptr_hi_q};
            eie_pkg::TLATCH_OFS: rd_word = {24'h0, tlatch_q};
            eie_pkg::STATUS_OFS: begin
                rd_word[eie_pkg::STAT_BUSY_BIT] = busy_q;
                rd_word[eie_pkg::STAT_SKIP_BIT] = skip_q;
            end
            eie_pkg::PM_ADDR_OFS: rd_word = 32'(pm_addr_q);
            eie_pkg::PM_DATA_OFS: rd_word = {16'h0, pmem[pm_addr_q]};
            default: rd_word = hit_dmem ? {24'h0, dmem[dm_idx]} : 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Instruction execution
    // ************************************************************
    wire exec = (st_q == eie_pkg::S_EXEC);
    wire [7:0] m = dmem[cmd_q.addr];
    wire [8:0] diff = {1'b0, acc_q} - {1'b0, m};
    wire [7:0] xr = acc_q ^ m;
    wire preinc = cmd_q.op == eie_pkg::OP_ITABRD || cmd_q.op == eie_pkg::OP_ITABRDL;
    wire last_pg = cmd_q.op == eie_pkg::OP_TABRDL || cmd_q.op == eie_pkg::OP_ITABRDL;
    // A pre-increment form reads with the already bumped pointer. [RQ11] [RQ12]
    wire [7:0] tptr_lo_eff = preinc ? 8'(tptr_lo_q + 8'h01) : tptr_lo_q;
    // The last page is the top page of program memory, so only the low pointer matters. [RQ9] [RQ10]
    wire [PAW-1:0] pm_idx = last_pg ? {{(PAW-8){1'b1}}, tptr_lo_eff} : {tptr_hi_q[PAW-9:0], tptr_lo_eff};
    wire [15:0] pword = pmem[pm_idx];

    logic mem_we, acc_we, tbl_we, skip_d;
    logic [7:0] mem_wd, acc_d;
    eie_pkg::eie_flags_t flg_d;
    always_comb begin
        mem_we = 1'b0;
        mem_wd = m;
        acc_we = 1'b0;
        acc_d = acc_q;
        flg_d = flg_q;
        tbl_we = 1'b0;
        skip_d = 1'b0;
        case (cmd_q.op)
            eie_pkg::OP_SUBM: begin
                mem_we = 1'b1; // [RQ1]
                mem_wd = diff[7:0];
                flg_d.c = ~diff[8]; // [RQ2]
                flg_d.aux_carry_flag = acc_q[3:0] >= m[3:0];
                flg_d.z = diff[7:0] == 8'h00;
                flg_d.overflow_flag = (acc_q[7] != m[7]) && (diff[7] != acc_q[7]);
                flg_d.signed_result_flag = ((acc_q[7] != m[7]) && (diff[7] != acc_q[7])) ^ diff[7];
                flg_d.carry_zero_flag = diff[7:0] == 8'h00;
            end
            eie_pkg::OP_SWAP: begin
                mem_we = 1'b1; // [RQ3]
                mem_wd = swap_nib(m);
            end
            eie_pkg::OP_SWAPA: begin
                acc_we = 1'b1; // [RQ4]
                acc_d = swap_nib(m);
            end
            eie_pkg::OP_SZ: begin
                mem_we = 1'b1; // [RQ5]
                skip_d = m == 8'h00;
            end
            eie_pkg::OP_SZA: begin
                acc_we = 1'b1; // [RQ7]
                skip_d = m == 8'h00;
            end
            eie_pkg::OP_SZ_BIT: skip_d = ~m[cmd_q.bitsel]; // [RQ8]
            eie_pkg::OP_TABRD, eie_pkg::OP_TABRDL, eie_pkg::OP_ITABRD, eie_pkg::OP_ITABRDL: begin
                mem_we = 1'b1; // [RQ9] [RQ10]
                mem_wd = pword[7:0];
                tbl_we = 1'b1;
            end
            eie_pkg::OP_XOR: begin
                acc_we = 1'b1; // [RQ13]
                acc_d = xr;
                flg_d.z = xr == 8'h00;
            end
            eie_pkg::OP_XORM: begin
                mem_we = 1'b1; // [RQ14]
                mem_wd = xr;
                flg_d.z = xr == 8'h00;
            end
            default: ;
        endcase
        if (cmd_q.op == eie_pkg::OP_SZA) begin
            acc_d = m;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Software registers are frozen while an instruction runs, so a bus write
    // can never race the execution result into the same register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= eie_pkg::S_IDLE;
            busy_q <= 1'b0;
            dcnt_q <= 2'h0;
            skip_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            case (st_q)
                eie_pkg::S_IDLE: begin
                    if (wr_cmd) begin
                        cmd_q <= cmd_in;
                        busy_q <= 1'b1;
                        st_q <= eie_pkg::S_EXEC;
                        skip_q <= 1'b0;
                    end
                end
                eie_pkg::S_EXEC: begin
                    skip_q <= skip_d;
                    dcnt_q <= eie_pkg::DUMMY_CYCLES;
                    busy_q <= skip_d;
                    st_q <= skip_d ? eie_pkg::S_DUMMY : eie_pkg::S_IDLE; // [RQ6]
                end
                eie_pkg::S_DUMMY: begin
                    dcnt_q <= dcnt_q - 2'h1;
                    if (dcnt_q == 2'h1) begin
                        st_q <= eie_pkg::S_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= eie_pkg::S_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= eie_pkg::ACC_RST;
            flg_q <= eie_pkg::FLAGS_RST;
            tptr_lo_q <= eie_pkg::TBL_RST;
            tptr_hi_q <= eie_pkg::TBL_RST;
            tlatch_q <= eie_pkg::TBL_RST;
            pm_addr_q <= '0;
        end else if (exec) begin
            acc_q <= acc_we ? acc_d : acc_q;
            flg_q <= flg_d;
            tptr_lo_q <= tbl_we ? tptr_lo_eff : tptr_lo_q; // [RQ11] [RQ12]
            tlatch_q <= tbl_we ? pword[15:8] : tlatch_q;
        end else begin
            acc_q <= wr_acc ? pwdata[7:0] : acc_q;
            flg_q <= wr_flg ? eie_pkg::eie_flags_t'(pwdata[5:0]) : flg_q;
            tptr_lo_q <= wr_tptr_lo ? pwdata[7:0] : tptr_lo_q;
            tptr_hi_q <= wr_tptr_hi ? pwdata[7:0] : tptr_hi_q;
            // Loading program words auto-advances the address for fast table fills.
            pm_addr_q <= wr_pma ? pwdata[PAW-1:0] : (wr_pmd ? pm_addr_q + 1'b1 : pm_addr_q);
        end
    end

    // Memories carry no reset; software loads them before use.
    always_ff @(posedge pclk) begin
        if (exec && mem_we) begin
            dmem[cmd_q.addr] <= mem_wd;
        end else if (wr_dm) begin
            dmem[dm_idx] <= pwdata[7:0];
        end
        if (wr_pmd) begin
            pmem[pm_addr_q] <= pwdata[15:0];
        end
    end

    // ************************************************************
    // APB answer: one wait state, then pready for one cycle
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            prdata_q <= (access & ~pready_q & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    assign busy = busy_q;
    assign skip = skip_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_subm;
        exec && cmd_q.op == eie_pkg::OP_SUBM |=> dmem[$past(cmd_q.addr)] == 8'($past(acc_q) - $past(m));
    endproperty
    a_subm: assert property (p_subm) else $error("subtract result not written to memory"); // [RQ1]

    property p_carry;
        exec && cmd_q.op == eie_pkg::OP_SUBM |=> flg_q.c == ($past(acc_q) >= $past(m));
    endproperty
    a_carry: assert property (p_carry) else $error("subtract carry wrong"); // [RQ2]

    property p_swap;
        exec && cmd_q.op == eie_pkg::OP_SWAP |=> dmem[$past(cmd_q.addr)] == {$past(m[3:0]), $past(m[7:4])}
            && $stable(flg_q);
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong"); // [RQ3]

    property p_swapa;
        exec && cmd_q.op == eie_pkg::OP_SWAPA |=> acc_q == {$past(m[3:0]), $past(m[7:4])} && $stable(flg_q)
            && dmem[$past(cmd_q.addr)] == $past(m);
    endproperty
    a_swapa: assert property (p_swapa) else $error("swap to accumulator wrong"); // [RQ4]

    property p_skip_len;
        exec && skip_d |=> busy [*2] ##1 !busy;
    endproperty
    a_skip_len: assert property (p_skip_len) else $error("skip did not last three cycles"); // [RQ6]

    property p_noskip_len;
        exec && !skip_d |=> !busy;
    endproperty
    a_noskip_len: assert property (p_noskip_len) else $error("plain instruction overran"); // [RQ6]

    property p_sza;
        exec && cmd_q.op == eie_pkg::OP_SZA |=> acc_q == $past(m) && skip == ($past(m) == 8'h00);
    endproperty
    a_sza: assert property (p_sza) else $error("skip with move wrong"); // [RQ7]

    property p_sz;
        exec && cmd_q.op == eie_pkg::OP_SZ |=> skip == ($past(m) == 8'h00) && $stable(flg_q);
    endproperty
    a_sz: assert property (p_sz) else $error("byte skip wrong"); // [RQ5]

    property p_szbit;
        exec && cmd_q.op == eie_pkg::OP_SZ_BIT |=> skip == !$past(m[cmd_q.bitsel]);
    endproperty
    a_szbit: assert property (p_szbit) else $error("bit skip wrong"); // [RQ8]

    property p_tab;
        exec && tbl_we |=> tlatch_q == $past(pword[15:8]) && dmem[$past(cmd_q.addr)] == $past(pword[7:0]);
    endproperty
    a_tab: assert property (p_tab) else $error("table read delivery wrong"); // [RQ9]

    property p_preinc;
        exec && preinc |=> tptr_lo_q == 8'($past(tptr_lo_q) + 8'h01);
    endproperty
    a_preinc: assert property (p_preinc) else $error("table pointer not pre-incremented"); // [RQ11]

    property p_xor;
        exec && cmd_q.op == eie_pkg::OP_XOR |=> acc_q == ($past(acc_q) ^ $past(m)) && flg_q.c == $past(flg_q.c)
            && flg_q.z == (acc_q == 8'h00);
    endproperty
    a_xor: assert property (p_xor) else $error("xor to accumulator wrong"); // [RQ13]

    property p_xorm;
        exec && cmd_q.op == eie_pkg::OP_XORM |=> dmem[$past(cmd_q.addr)] == ($past(acc_q) ^ $past(m))
            && flg_q.z == (dmem[$past(cmd_q.addr)] == 8'h00) && flg_q.c == $past(flg_q.c);
    endproperty
    a_xorm: assert property (p_xorm) else $error("xor to memory wrong"); // [RQ14]

    property p_lastpg;
        exec && cmd_q.op == eie_pkg::OP_TABRDL |=> tlatch_q == pmem[{{(PAW-8){1'b1}}, tptr_lo_q}][15:8];
    endproperty
    a_lastpg: assert property (p_lastpg) else $error("last page table read wrong"); // [RQ10]

    property p_lastpg_inc;
        exec && cmd_q.op == eie_pkg::OP_ITABRDL |=>
            dmem[$past(cmd_q.addr)] == pmem[{{(PAW-8){1'b1}}, tptr_lo_q}][7:0];
    endproperty
    a_lastpg_inc: assert property (p_lastpg_inc) else $error("pre-increment last page read wrong"); // [RQ12]

    c_skip: cover property (exec && skip_d ##3 !busy);
    c_subm_neg: cover property (exec && cmd_q.op == eie_pkg::OP_SUBM && diff[8]);
    c_lastpg: cover property (exec && cmd_q.op == eie_pkg::OP_ITABRDL);

endmodule : eie_core

`default_nettype wire

/* shared/eie_pkg.sv */
`default_nettype none

package eie_pkg;

    // ************************************************************
    // Register offsets (byte addresses on the APB bus)
    // ************************************************************
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] ACC_OFS = 8'h04;
    localparam logic [7:0] FLAGS_OFS = 8'h08;
    localparam logic [7:0] TPTR_LO_OFS = 8'h0c;
    localparam logic [7:0] TPTR_HI_OFS = 8'h10;
    localparam logic [7:0] TLATCH_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] PM_ADDR_OFS = 8'h1c;
    localparam logic [7:0] PM_DATA_OFS = 8'h20;
    localparam logic [7:0] DMEM_OFS = 8'h40;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_BIT_LSB = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SKIP_BIT = 1;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] TBL_RST = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam int INSTR_CYCLES_SKIP = 3;
    localparam logic [1:0] DUMMY_CYCLES = 2'(INSTR_CYCLES_SKIP - 1);

    typedef enum logic [3:0] {
        OP_SUBM = 4'h0,
        OP_SWAP = 4'h1,
        OP_SWAPA = 4'h2,
        OP_SZ = 4'h3,
        OP_SZA = 4'h4,
        OP_SZ_BIT = 4'h5,
        OP_TABRD = 4'h6,
        OP_TABRDL = 4'h7,
        OP_ITABRD = 4'h8,
        OP_ITABRDL = 4'h9,
        OP_XOR = 4'ha,
        OP_XORM = 4'hb
    } eie_op_t;

    typedef struct packed {
        logic [2:0] bitsel;
        logic [3:0] addr;
        logic [3:0] op;
    } eie_cmd_t;

    typedef struct packed {
        logic carry_zero_flag;
        logic signed_result_flag;
        logic overflow_flag;
        logic z;
        logic aux_carry_flag;
        logic c;
    } eie_flags_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_EXEC = 3'b010,
        S_DUMMY = 3'b100
    } eie_state_t;

endpackage : eie_pkg

`default_nettype wire

/* dv/extended_instr_exec_swap_skip_table_xor_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module extended_instr_exec_swap_skip_table_xor_tb;

    // ************************************************************
    // Signals and case table
    // ************************************************************
    localparam logic [7:0] ptr_lo_a = 8'h0c;
    localparam logic [7:0] ptr_hi_a = 8'h10;
    localparam logic [7:0] latch_hi_a = 8'h14;

    typedef struct packed {
        logic [3:0] op;
        logic [3:0] addr;
        logic [2:0] bsel;
        logic [5:0] fl_in;
        logic [7:0] acc_in;
        logic [7:0] mem_in;
        logic [7:0] e_acc;
        logic [7:0] e_mem;
        logic [5:0] e_fl;
        logic e_skip;
    } eie_row_t;

    // Flag presets differ from row to row, except in rows 0-1 and 2-3, so that a stuck or wrongly written flag shows.
    eie_row_t rows [18] = '{
        '{4'h0, 4'h0, 3'h0, 6'h3f, 8'h05, 8'h03, 8'h05, 8'h02, 6'h03, 1'b0},
        '{4'h0, 4'h1, 3'h0, 6'h3f, 8'h03, 8'h05, 8'h03, 8'hfe, 6'h10, 1'b0},
        '{4'h0, 4'h2, 3'h0, 6'h00, 8'h80, 8'h01, 8'h80, 8'h7f, 6'h19, 1'b0},
        '{4'h0, 4'hf, 3'h0, 6'h00, 8'h44, 8'h44, 8'h44, 8'h00, 6'h27, 1'b0},
        '{4'h1, 4'h3, 3'h0, 6'h2b, 8'h99, 8'h3c, 8'h99, 8'hc3, 6'h2b, 1'b0},
        '{4'h2, 4'h4, 3'h0, 6'h14, 8'h99, 8'ha5, 8'h5a, 8'ha5, 6'h14, 1'b0},
        '{4'h3, 4'h5, 3'h0, 6'h2b, 8'h99, 8'h00, 8'h99, 8'h00, 6'h2b, 1'b1},
        '{4'h3, 4'h6, 3'h0, 6'h14, 8'h99, 8'h01, 8'h99, 8'h01, 6'h14, 1'b0},
        '{4'h4, 4'h7, 3'h0, 6'h2b, 8'h99, 8'h00, 8'h00, 8'h00, 6'h2b, 1'b1},
        '{4'h4, 4'h8, 3'h0, 6'h14, 8'h99, 8'h5a, 8'h5a, 8'h5a, 6'h14, 1'b0},
        '{4'h5, 4'h9, 3'h3, 6'h2b, 8'h99, 8'hf7, 8'h99, 8'hf7, 6'h2b, 1'b1},
        '{4'h5, 4'ha, 3'h3, 6'h14, 8'h99, 8'h08, 8'h99, 8'h08, 6'h14, 1'b0},
        '{4'h5, 4'hb, 3'h7, 6'h2b, 8'h99, 8'h80, 8'h99, 8'h80, 6'h2b, 1'b0},
        '{4'h5, 4'hc, 3'h0, 6'h14, 8'h99, 8'hfe, 8'h99, 8'hfe, 6'h14, 1'b1},
        '{4'ha, 4'hd, 3'h0, 6'h2f, 8'h0f, 8'hf0, 8'hff, 8'hf0, 6'h2b, 1'b0},
        '{4'hb, 4'he, 3'h0, 6'h2b, 8'h3c, 8'h3c, 8'h3c, 8'h00, 6'h2f, 1'b0},
        '{4'hb, 4'h0, 3'h0, 6'h2f, 8'h01, 8'h03, 8'h01, 8'h02, 6'h2b, 1'b0},
        '{4'hc, 4'h1, 3'h0, 6'h2b, 8'h99, 8'h3c, 8'h99, 8'h3c, 6'h2b, 1'b0}
    };

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, skip, e, rel;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int num_errors, n_compared;

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    eie_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .busy(busy), .skip(skip));

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task end_of_test;
        $display("Compared %0d values, %0d mismatches", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // A spare edge after a release keeps psel from being lowered and raised in one step.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        if (rel) @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED pready expected 1 seen 0");
            end_of_test;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        rel = 1'b1;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input string name, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, q);
    endtask : rd

    function automatic logic [7:0] dm(input logic [3:0] a);
        return eie_pkg::DMEM_OFS + {2'b00, a, 2'b00};
    endfunction : dm

    task run(input logic [3:0] op, input logic [3:0] a, input logic [2:0] b, input int cyc);
        int n;
        int c;
        wr(eie_pkg::CMD_OFS, {13'h0, b, 4'h0, a, 4'h0, op});
        c = 0;
        for (n = 0; n < 12; n++) begin
            @(posedge pclk);
            if (busy === 1'b1) c++;
            else if (c > 0) break;
        end
        rel = 1'b0;
        chk("busy cycles", cyc, c);
    endtask : run

    task tab(input logic [3:0] op, input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi,
        input logic [7:0] ptr);
        run(op, a, 3'h0, 1);
        rd(dm(a), "table low byte", {24'h0, lo});
        rd(latch_hi_a, "table high latch", {24'h0, hi});
        rd(ptr_lo_a, "pointer low", {24'h0, ptr});
        rd(eie_pkg::FLAGS_OFS, "flags", 32'h15);
    endtask : tab

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        rel = 1'b0;
        num_errors = 0;
        n_compared = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            wr(dm(rows[i].addr), {24'h0, rows[i].mem_in});
            wr(eie_pkg::ACC_OFS, {24'h0, rows[i].acc_in});
            wr(eie_pkg::FLAGS_OFS, {26'h0, rows[i].fl_in});
            run(rows[i].op, rows[i].addr, rows[i].bsel, rows[i].e_skip ? 3 : 1);
            rd(eie_pkg::STATUS_OFS, "skip", {30'h0, rows[i].e_skip, 1'b0});
            chk("skip pin", {31'h0, rows[i].e_skip}, {31'h0, skip});
            rd(eie_pkg::ACC_OFS, "accumulator", {24'h0, rows[i].e_acc});
            rd(dm(rows[i].addr), "data byte", {24'h0, rows[i].e_mem});
            rd(eie_pkg::FLAGS_OFS, "flags", {26'h0, rows[i].e_fl});
        end
        wr(eie_pkg::PM_ADDR_OFS, 32'h105);
        wr(eie_pkg::PM_DATA_OFS, 32'ha1b2);
        wr(eie_pkg::PM_DATA_OFS, 32'hc3d4);
        wr(eie_pkg::PM_ADDR_OFS, 32'h305);
        wr(eie_pkg::PM_DATA_OFS, 32'h1122);
        wr(eie_pkg::PM_DATA_OFS, 32'h3344);
        wr(ptr_lo_a, 32'h05);
        wr(ptr_hi_a, 32'h01);
        wr(eie_pkg::FLAGS_OFS, 32'h15);
        tab(eie_pkg::OP_TABRD, 4'h2, 8'hb2, 8'ha1, 8'h05);
        tab(eie_pkg::OP_TABRDL, 4'h3, 8'h22, 8'h11, 8'h05);
        tab(eie_pkg::OP_ITABRD, 4'h4, 8'hd4, 8'hc3, 8'h06);
        wr(ptr_lo_a, 32'h05);
        tab(eie_pkg::OP_ITABRDL, 4'h5, 8'h44, 8'h33, 8'h06);
        wr(latch_hi_a, 32'h77);
        rd(latch_hi_a, "read-only latch", 32'h33);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped pslverr", 32'h1, {31'h0, e});
        chk("unmapped read", 32'h0, q);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rel = 1'b0;
        rd(eie_pkg::ACC_OFS, "accumulator after reset", 32'h0);
        rd(eie_pkg::FLAGS_OFS, "flags after reset", 32'h0);
        rd(ptr_lo_a, "pointer low after reset", 32'h0);
        rd(ptr_hi_a, "pointer high after reset", 32'h0);
        rd(latch_hi_a, "latch after reset", 32'h0);
        rd(eie_pkg::STATUS_OFS, "status after reset", 32'h0);
        end_of_test;
    end

endmodule : extended_instr_exec_swap_skip_table_xor_tb

`default_nettype wire
